// File: src/pss_map.svh
// Constants for the position synchronized start block
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH
`define PSS_ERR_NONE 16'h0000
`define PSS_ERR_SUB_NO_ORIGIN 16'h0158
`define PSS_ERR_LEAD_NO_ORIGIN 16'h015a
`define PSS_ERR_SAME_AXIS 16'h015b
`define PSS_ERR_LEAD_IS_SUB 16'h015d
`define PSS_AXIS_X 1'b0
`define PSS_AXIS_Y 1'b1
`define PSS_STEP_MAX 7'h50
`endif

// File: src/pss_pkg.sv
// Types for the position synchronized start block
package pss_pkg;
    typedef enum logic [1:0] {
        PSS_IDLE = 2'b00,
        PSS_ARMED = 2'b01
    } pss_state_t;
endpackage

// File: src/pss_axis_slot.sv
// One axis synchronization slot: arm, wait for leader position, fire start
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"
module pss_axis_slot
    import pss_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int STEP_W = 7
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic arm_i,
    input wire logic [STEP_W-1:0] arm_step_i,
    input wire logic arm_leader_i,
    input wire logic signed [POS_W-1:0] arm_target_i,
    input wire logic stop_i,
    input wire logic signed [POS_W-1:0] leader_pos_i,
    input wire logic leader_running_i,
    output logic armed_o,
    output logic leader_o,
    output logic fire_o,
    output logic [STEP_W-1:0] fire_step_o
);
    pss_state_t state, next_state;
    logic [STEP_W-1:0] step, next_step;
    logic leader, next_leader;
    logic signed [POS_W-1:0] target, next_target;
    logic fire, next_fire;

    always_comb begin
        next_state = state;
        next_step = step;
        next_leader = leader;
        next_target = target;
        next_fire = 1'b0;
        case (state)
            PSS_IDLE: begin
                if (arm_i) begin
                    next_state = PSS_ARMED;
                    next_step = arm_step_i;
                    next_leader = arm_leader_i;
                    next_target = arm_target_i;
                end
            end
            PSS_ARMED: begin
                if (stop_i) begin
                    next_state = PSS_IDLE;
                end else if (leader_running_i && leader_pos_i == target) begin
                    next_state = PSS_IDLE;
                    next_fire = 1'b1;
                end
            end
            default: next_state = PSS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= PSS_IDLE;
            step <= '0;
            leader <= 1'b0;
            target <= '0;
            fire <= 1'b0;
        end else begin
            state <= next_state;
            step <= next_step;
            leader <= next_leader;
            target <= next_target;
            fire <= next_fire;
        end
    end

    assign armed_o = (state == PSS_ARMED);
    assign leader_o = leader;
    assign fire_o = fire;
    assign fire_step_o = step;
endmodule
`default_nettype wire

// File: src/pss_position_sync_start.sv
// Position synchronized start logic for a two-axis pulse positioning unit
`timescale 1ns/10ps
`default_nettype none
`include "pss_map.svh"
module pss_position_sync_start
    import pss_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int STEP_W = 7
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic position_sync_start_request_i,
    input wire logic sub_axis_select_i,
    input wire logic leader_axis_select_i,
    input wire logic [STEP_W-1:0] step_select_i,
    input wire logic signed [POS_W-1:0] leader_target_position_i,
    input wire logic [1:0] decel_stop_request_i,
    input wire logic signed [POS_W-1:0] x_present_position_i,
    input wire logic signed [POS_W-1:0] y_present_position_i,
    input wire logic [1:0] axis_running_i,
    input wire logic [1:0] origin_done_i,
    input wire logic [1:0] axis_error_i,
    output logic x_axis_busy_flag_o,
    output logic y_axis_busy_flag_o,
    output logic x_axis_origin_done_flag_o,
    output logic y_axis_origin_done_flag_o,
    output logic x_axis_error_flag_o,
    output logic y_axis_error_flag_o,
    output logic [1:0] pulse_inhibit_o,
    output logic [1:0] sync_start_o,
    output logic [STEP_W-1:0] sync_start_step_o,
    output logic done_o,
    output logic [15:0] stat_o
);
    logic req_d, next_req_d;
    logic done, next_done;
    logic [15:0] stat, next_stat;
    logic [STEP_W-1:0] start_step, next_start_step;
    logic [1:0] start, next_start;
    logic [1:0] arm;
    logic [1:0] armed;
    logic [1:0] slot_leader;
    logic [1:0] fire;
    logic [STEP_W-1:0] fire_step [2];
    logic req_edge;

    // Present position of the axis that a select code names
    function automatic logic signed [POS_W-1:0] axis_pos(input logic sel);
        axis_pos = (sel == `PSS_AXIS_Y) ? y_present_position_i : x_present_position_i;
    endfunction

    assign req_edge = position_sync_start_request_i && !req_d;

    always_comb begin
        next_req_d = position_sync_start_request_i;
        next_done = 1'b0;
        next_stat = stat;
        arm = 2'b00;
        if (req_edge) begin
            // Checks in priority order; the first failure is the one reported
            if (leader_axis_select_i == sub_axis_select_i) begin
                next_stat = `PSS_ERR_SAME_AXIS;
            end else if (!origin_done_i[leader_axis_select_i]) begin
                next_stat = `PSS_ERR_LEAD_NO_ORIGIN;
            end else if (!origin_done_i[sub_axis_select_i]) begin
                next_stat = `PSS_ERR_SUB_NO_ORIGIN;
            end else if (armed[leader_axis_select_i]) begin
                next_stat = `PSS_ERR_LEAD_IS_SUB;
            end else begin
                next_stat = `PSS_ERR_NONE;
                next_done = 1'b1;
                arm[sub_axis_select_i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_d <= 1'b0;
            done <= 1'b0;
            stat <= `PSS_ERR_NONE;
        end else begin
            req_d <= next_req_d;
            done <= next_done;
            stat <= next_stat;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_slot
            pss_axis_slot #(
                .POS_W(POS_W),
                .STEP_W(STEP_W)
            ) u_slot (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .arm_i(arm[g]),
                .arm_step_i(step_select_i),
                .arm_leader_i(leader_axis_select_i),
                .arm_target_i(leader_target_position_i),
                .stop_i(decel_stop_request_i[g]),
                .leader_pos_i(axis_pos(slot_leader[g])),
                .leader_running_i(axis_running_i[slot_leader[g]]),
                .armed_o(armed[g]),
                .leader_o(slot_leader[g]),
                .fire_o(fire[g]),
                .fire_step_o(fire_step[g])
            );
        end
    endgenerate

    // Start pulse and step registered so data outputs come from flops
    always_comb begin
        next_start = fire;
        next_start_step = start_step;
        if (fire[1]) begin
            next_start_step = fire_step[1];
        end else if (fire[0]) begin
            next_start_step = fire_step[0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start <= 2'b00;
            start_step <= '0;
        end else begin
            start <= next_start;
            start_step <= next_start_step;
        end
    end

    // Busy holds while armed even though no pulses leave the axis
    assign x_axis_busy_flag_o = armed[0] || axis_running_i[0];
    assign y_axis_busy_flag_o = armed[1] || axis_running_i[1];
    assign pulse_inhibit_o = armed;
    assign x_axis_origin_done_flag_o = origin_done_i[0];
    assign y_axis_origin_done_flag_o = origin_done_i[1];
    assign x_axis_error_flag_o = axis_error_i[0];
    assign y_axis_error_flag_o = axis_error_i[1];
    assign sync_start_o = start;
    assign sync_start_step_o = start_step;
    assign done_o = done;
    assign stat_o = stat;

    property p_arm_edge;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (req_edge && done == 1'b0 && next_done) |=> armed[$past(sub_axis_select_i)];
    endproperty
    a_arm_edge: assert property (p_arm_edge) else $error("Accepted request did not arm sub-axis");

    property p_busy;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        armed[1] |-> (y_axis_busy_flag_o && pulse_inhibit_o[1]);
    endproperty
    a_busy: assert property (p_busy) else $error("Armed Y axis not busy or emitting");

    logic signed [POS_W-1:0] leader_target_position_q0;
    sequence s_hit0;
        armed[0] && !decel_stop_request_i[0] && axis_running_i[slot_leader[0]]
            && axis_pos(slot_leader[0]) == leader_target_position_q0;
    endsequence
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            leader_target_position_q0 <= '0;
        end else if (arm[0]) begin
            leader_target_position_q0 <= leader_target_position_i;
        end
    end
    property p_fire;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        s_hit0 |-> ##2 sync_start_o[0];
    endproperty
    a_fire: assert property (p_fire) else $error("X sub-axis not started at target");

    property p_no_early;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (armed[0] && !axis_running_i[slot_leader[0]]) |=> !fire[0];
    endproperty
    a_no_early: assert property (p_no_early) else $error("Start fired with leader stopped");

    property p_origin;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (req_edge && leader_axis_select_i != sub_axis_select_i && !origin_done_i[leader_axis_select_i])
            |=> (stat_o == `PSS_ERR_LEAD_NO_ORIGIN && !done_o);
    endproperty
    a_origin: assert property (p_origin) else $error("Missing leader origin not reported");

    property p_same;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (req_edge && leader_axis_select_i == sub_axis_select_i) |=> (stat_o == `PSS_ERR_SAME_AXIS);
    endproperty
    a_same: assert property (p_same) else $error("Same axis not reported");

    property p_chain;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (req_edge && leader_axis_select_i != sub_axis_select_i && &origin_done_i
            && armed[leader_axis_select_i]) |=> (stat_o == `PSS_ERR_LEAD_IS_SUB && armed == $past(armed));
    endproperty
    a_chain: assert property (p_chain) else $error("Chained sync not refused");

    property p_stop;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (armed[1] && decel_stop_request_i[1]) |=> (!armed[1] ##1 !sync_start_o[1]);
    endproperty
    a_stop: assert property (p_stop) else $error("Stop did not cancel Y sub-axis");

    property p_flags;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (x_axis_origin_done_flag_o == origin_done_i[0]) && (y_axis_error_flag_o == axis_error_i[1]);
    endproperty
    a_flags: assert property (p_flags) else $error("Status flags do not follow axis");

    property p_done;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        done_o |-> (stat_o == `PSS_ERR_NONE) ##1 !done_o;
    endproperty
    a_done: assert property (p_done) else $error("Done without zero status or too long");
endmodule
`default_nettype wire

// File: verification/pss_axis_model.sv
// Behavioural model of the two pulse axes around the synchronized start block
`timescale 1ns/10ps
`default_nettype none
module pss_axis_model (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [1:0] run_i,
    input wire logic [1:0] start_i,
    input wire logic [1:0] stop_i,
    input wire logic [1:0] inhibit_i,
    output logic [1:0] running_o,
    output logic signed [31:0] x_pos_o,
    output logic signed [31:0] y_pos_o
);
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            running_o <= 2'h0;
            x_pos_o <= 32'sh0;
            y_pos_o <= 32'sh0;
        end else begin
            // Stop wins over start, so a cancelled sub-axis never moves
            running_o <= (running_o | run_i | start_i) & ~stop_i;
            // An inhibited axis emits no pulses, so its position holds
            if (running_o[0] && !inhibit_i[0]) x_pos_o <= x_pos_o + 32'sh1;
            if (running_o[1] && !inhibit_i[1]) y_pos_o <= y_pos_o + 32'sh1;
        end
    end
endmodule
`default_nettype wire

// File: verification/pss_position_sync_start_tb_top.sv
// Self-checking bench for the position synchronized start block
`timescale 1ns/10ps
`default_nettype none
module pss_position_sync_start_tb_top
    import pss_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic sub = 1'b0;
    logic lead = 1'b0;
    logic [6:0] step = 7'h0;
    logic signed [31:0] tgt = 32'sh0;
    logic [1:0] stop = 2'h0;
    logic [1:0] run = 2'h0;
    logic [1:0] origin = 2'h3;
    logic [1:0] err = 2'h0;
    logic [1:0] running, inhibit, sstart;
    logic signed [31:0] x_pos, y_pos;
    logic x_busy, y_busy, x_org, y_org, x_err, y_err, done;
    logic [6:0] sstep;
    logic [15:0] stat;
    int error_cnt = 0;
    int total_checks = 0;

    initial begin
        forever #4 clk = ~clk;
    end

    pss_position_sync_start pss_position_sync_start_inst (.ref_clk_i(clk), .nrst_i(nrst),
        .position_sync_start_request_i(req), .sub_axis_select_i(sub), .leader_axis_select_i(lead),
        .step_select_i(step), .leader_target_position_i(tgt), .decel_stop_request_i(stop),
        .x_present_position_i(x_pos), .y_present_position_i(y_pos), .axis_running_i(running),
        .origin_done_i(origin), .axis_error_i(err), .x_axis_busy_flag_o(x_busy), .y_axis_busy_flag_o(y_busy),
        .x_axis_origin_done_flag_o(x_org), .y_axis_origin_done_flag_o(y_org), .x_axis_error_flag_o(x_err),
        .y_axis_error_flag_o(y_err), .pulse_inhibit_o(inhibit), .sync_start_o(sstart),
        .sync_start_step_o(sstep), .done_o(done), .stat_o(stat));

    pss_axis_model pss_axis_model_inst (.ref_clk_i(clk), .nrst_i(nrst), .run_i(run), .start_i(sstart),
        .stop_i(stop), .inhibit_i(inhibit), .running_o(running), .x_pos_o(x_pos), .y_pos_o(y_pos));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, msg, got, exp);
        end
    endtask

    task automatic request(input logic s, input logic l, input logic [6:0] st, input logic [31:0] t,
                           input logic [15:0] e);
        @(negedge clk);
        sub = s;
        lead = l;
        step = st;
        tgt = t;
        req = 1'b1;
        // Done stands for a single cycle, so look right after the taking edge
        @(negedge clk);
        chk({31'h0, done}, {31'h0, e === 16'h0}, "done pulse");
        chk({16'h0, stat}, {16'h0, e}, "status code");
        req = 1'b0;
        @(negedge clk);
        chk({31'h0, done}, 32'h0, "done lasts one cycle");
    endtask

    // Stop both axes so the next test starts from rest
    task automatic stop_all();
        @(negedge clk);
        stop = 2'h3;
        @(negedge clk);
        stop = 2'h0;
        @(negedge clk);
    endtask

    task automatic t_sync();
        int n;
        request(1'b1, 1'b0, 7'h50, 32'h14, 16'h0);
        chk({30'h0, y_busy, inhibit[1]}, 32'h3, "armed sub busy and silent");
        run = 2'h1;
        @(negedge clk);
        run = 2'h0;
        n = 0;
        while (sstart[1] !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk({23'h0, sstart, sstep}, {23'h0, 2'b10, 7'h50}, "sub start with step");
        chk({31'h0, x_pos > 32'sh14 && x_pos < 32'sh18}, 32'h1, "leader reached target");
        chk({31'h0, inhibit[1]}, 32'h0, "inhibit released");
        stop_all();
        $display("test sync finished");
    endtask

    // X as sub-axis behind a running Y leader, target taken from where Y rests
    task automatic t_sync_x();
        int n;
        logic signed [31:0] tg;
        tg = y_pos + 32'sha;
        request(1'b0, 1'b1, 7'h1, tg, 16'h0);
        chk({30'h0, x_busy, inhibit[0]}, 32'h3, "armed X sub busy and silent");
        run = 2'h2;
        @(negedge clk);
        run = 2'h0;
        n = 0;
        while (sstart[0] !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk({23'h0, sstart, sstep}, {23'h0, 2'b01, 7'h1}, "X sub start with step");
        // Match is seen one edge after the leader lands, pulse one edge later
        chk({31'h0, y_pos == tg + 32'sh2}, 32'h1, "Y leader reached target");
        chk({31'h0, inhibit[0]}, 32'h0, "X inhibit released");
        stop_all();
        $display("test sync x finished");
    endtask

    task automatic t_err();
        request(1'b0, 1'b0, 7'h1, 32'h5, 16'h015b);
        origin = 2'b10;
        request(1'b1, 1'b0, 7'h1, 32'h5, 16'h015a);
        origin = 2'b01;
        request(1'b1, 1'b0, 7'h1, 32'h5, 16'h0158);
        origin = 2'b11;
        chk({28'h0, x_busy, y_busy, inhibit}, 32'h0, "nothing armed on error");
        $display("test errors finished");
    endtask

    task automatic t_chain();
        request(1'b1, 1'b0, 7'h2, 32'h3e8, 16'h0);
        request(1'b0, 1'b1, 7'h2, 32'h0, 16'h015d);
        chk({29'h0, x_busy, inhibit}, 32'h2, "chained request not armed");
        @(negedge clk);
        stop = 2'b10;
        @(negedge clk);
        stop = 2'h0;
        @(negedge clk);
        chk({28'h0, y_busy, inhibit, sstart[1]}, 32'h0, "stop cancels sub");
        $display("test chain finished");
    endtask

    task automatic t_flags();
        @(negedge clk);
        origin = 2'b01;
        err = 2'b10;
        @(negedge clk);
        chk({28'h0, x_org, y_org, x_err, y_err}, 32'h9, "origin and error flags");
        origin = 2'b11;
        err = 2'b00;
        $display("test flags finished");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_sync();
        t_sync_x();
        t_err();
        t_chain();
        t_flags();
        end_of_test();
    end

    // All tests take well under a thousand cycles
    initial begin
        #40000;
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
